/* src/ubbpp_top.sv */
`timescale 1ns/1ps
// How it works
// - Async: written bytes go to output pins
// - Async output pace comes from baud tick
// - Output pins hold last value when idle
// - Async: read and write strobes leave chip
// - Code 0x01 selects asynchronous variant
// - Code 0x04 selects synchronous variant
// - Code 0x00 returns port to reset state
// - Direction mask kept until next setup
// - Sync: outputs change only on popped byte
// - Sync: sample only while handling written byte
// - Sync: need room for sample first
// - Sample pins before applying new output
// - Sync: strobe off, sample, strobe on with output
// - Sync: write strobe one clock after output
// - Full sequence runs even with all inputs
// - Write strobe tied to popping a byte
module ubbpp_top (
	input wire logic CLK,
	input wire logic SRST,
	input wire ubbpp_pkg::ubbpp_cmd_type MODE_CMD,
	input wire logic [15:0] BAUD_DIV,
	input wire logic [7:0] HOST_WR_DATA,
	input wire logic HOST_WR_VALID,
	output logic HOST_WR_READY,
	output logic [7:0] HOST_RD_DATA,
	output logic HOST_RD_VALID,
	input wire logic HOST_RD_READY,
	input wire logic [7:0] PIN_IN,
	output logic [7:0] PIN_OUT,
	output logic [7:0] PIN_OE,
	output logic PIN_SAMPLE_STROBE_N,
	output logic PIN_UPDATE_STROBE_N
);
	ubbpp_pkg::ubbpp_state_type st_q; // Registered controller state
	ubbpp_pkg::ubbpp_state_type st_d; // Next controller state
	ubbpp_pkg::ubbpp_mode_type cmd_mode; // Decoded command variant
	logic [7:0] h2p_data; // Head of host_to_port_fifo
	logic h2p_valid; // A host byte waits
	logic p2h_ready; // port_to_host_fifo has room
	logic tick; // Baud pacing tick

	// Bytes from the host toward the pins
	ubbpp_fifo #(
		.W(ubbpp_pkg::DATA_W),
		.DEPTH(ubbpp_pkg::FIFO_DEPTH)
	) host_to_port_fifo (
		.clk(CLK),
		.srst(SRST),
		.in_data(HOST_WR_DATA),
		.in_valid(HOST_WR_VALID),
		.in_ready(HOST_WR_READY),
		.out_data(h2p_data),
		.out_valid(h2p_valid),
		.out_ready(st_q.pop)
	);

	// Pin samples back to the host
	ubbpp_fifo #(
		.W(ubbpp_pkg::DATA_W),
		.DEPTH(ubbpp_pkg::FIFO_DEPTH)
	) port_to_host_fifo (
		.clk(CLK),
		.srst(SRST),
		.in_data(st_q.push_data),
		.in_valid(st_q.push),
		.in_ready(p2h_ready),
		.out_data(HOST_RD_DATA),
		.out_valid(HOST_RD_VALID),
		.out_ready(HOST_RD_READY)
	);

	// Pacing runs only in the asynchronous variant
	ubbpp_baud baud_gen (
		.clk(CLK),
		.srst(SRST),
		.run(st_q.mode == ubbpp_pkg::M_ASYNC),
		.div(BAUD_DIV),
		.tick(tick)
	);

	// Next-state logic for all variants
	always_comb begin
		st_d = st_q;
		st_d.pop = 1'b0;
		st_d.push = 1'b0;
		cmd_mode = ubbpp_pkg::decode_mode(MODE_CMD.code);
		unique case (st_q.mode)
			// Async: everything moves on baud ticks
			ubbpp_pkg::M_ASYNC: begin
				st_d.rd_n = 1'b1;
				st_d.wr_n = 1'b1;
				st_d.seq = ubbpp_pkg::S_IDLE;
				// Popped byte lands on the pins with a write strobe
				if (st_q.pop) begin
					st_d.pin_out = h2p_data;
					st_d.wr_n = 1'b0;
				end
				// Ticks are at least two cycles apart, so no pop overlaps
				if (tick) begin
					st_d.pop = h2p_valid;
					if (p2h_ready) begin
						st_d.push = 1'b1;
						st_d.push_data = PIN_IN;
						st_d.rd_n = 1'b0;
					end
				end
			end
			// Sync: one strict sequence per written byte
			ubbpp_pkg::M_SYNC: begin
				unique case (st_q.seq)
					// Start only with a byte and room for its sample
					ubbpp_pkg::S_IDLE: begin
						if (h2p_valid && p2h_ready) begin
							st_d.seq = ubbpp_pkg::S_SAMPLE;
							st_d.rd_n = 1'b1;
							st_d.pop = 1'b1;
						end
					end
					// Pins still show the old byte here
					ubbpp_pkg::S_SAMPLE: begin
						st_d.push = 1'b1;
						st_d.push_data = PIN_IN;
						st_d.next_out = h2p_data;
						st_d.seq = ubbpp_pkg::S_APPLY;
					end
					// Strobe returns as outputs switch
					ubbpp_pkg::S_APPLY: begin
						st_d.rd_n = 1'b0;
						st_d.pin_out = st_q.next_out;
						st_d.seq = ubbpp_pkg::S_SETUP;
					end
					// One cycle of data setup before the strobe
					ubbpp_pkg::S_SETUP: begin
						st_d.wr_n = 1'b0;
						st_d.seq = ubbpp_pkg::S_WSTB;
					end
					// Strobe ends after one cycle
					ubbpp_pkg::S_WSTB: begin
						st_d.wr_n = 1'b1;
						st_d.seq = ubbpp_pkg::S_IDLE;
					end
					// Unused codes recover to idle
					default: begin
						st_d.seq = ubbpp_pkg::S_IDLE;
					end
				endcase
			end
			// Idle: strobes parked, pins left alone
			ubbpp_pkg::M_IDLE: begin
				st_d.rd_n = 1'b1;
				st_d.wr_n = 1'b1;
				st_d.seq = ubbpp_pkg::S_IDLE;
			end
			// Illegal code recovers to reset state
			default: begin
				st_d = ubbpp_pkg::STATE_RESET;
			end
		endcase
		// A new setup command wins over any step in flight
		if (MODE_CMD.valid) begin
			st_d.mode = cmd_mode;
			st_d.seq = ubbpp_pkg::S_IDLE;
			st_d.pop = 1'b0;
			st_d.push = 1'b0;
			st_d.wr_n = 1'b1;
			// Sync strobe rests active, others rest high
			st_d.rd_n = (cmd_mode != ubbpp_pkg::M_SYNC);
			st_d.dir = MODE_CMD.mask;
			if (cmd_mode == ubbpp_pkg::M_IDLE) begin
				st_d.dir = ubbpp_pkg::DIR_RESET;
				st_d.pin_out = ubbpp_pkg::PIN_OUT_RESET;
			end
		end
		if (SRST) begin
			st_d = ubbpp_pkg::STATE_RESET;
		end
	end

	// State register; pins keep the last value until a new one comes
	always_ff @(posedge CLK) begin
		st_q <= st_d;
	end

	assign PIN_OUT = st_q.pin_out;
	assign PIN_OE = st_q.dir;
	assign PIN_SAMPLE_STROBE_N = st_q.rd_n;
	assign PIN_UPDATE_STROBE_N = st_q.wr_n;

	default clocking cb @(posedge CLK); endclocking
	default disable iff (SRST);

	// Pin side of one synchronous byte
	sequence rd_release_s;
		st_q.seq == ubbpp_pkg::S_SAMPLE && PIN_SAMPLE_STROBE_N;
	endsequence
	// Sample leaves with the strobe still high; strobe drops as the pins switch
	sequence push_apply_s;
		st_q.push && PIN_SAMPLE_STROBE_N ##1
		!PIN_SAMPLE_STROBE_N && PIN_OUT == $past(st_q.next_out);
	endsequence
	sequence wr_pulse_s;
		PIN_UPDATE_STROBE_N ##1 !PIN_UPDATE_STROBE_N ##1 PIN_UPDATE_STROBE_N;
	endsequence

	mode_async_a: assert property (
		MODE_CMD.valid && MODE_CMD.code == ubbpp_pkg::CODE_ASYNC
		|=> st_q.mode == ubbpp_pkg::M_ASYNC && PIN_OE == $past(MODE_CMD.mask))
		else $error("async code did not select async variant");
	mode_sync_a: assert property (
		MODE_CMD.valid && MODE_CMD.code == ubbpp_pkg::CODE_SYNC
		|=> st_q.mode == ubbpp_pkg::M_SYNC && !PIN_SAMPLE_STROBE_N)
		else $error("sync code did not select sync variant");
	mode_reset_a: assert property (
		MODE_CMD.valid && MODE_CMD.code == ubbpp_pkg::CODE_RESET
		|=> PIN_OE == 8'h00 && PIN_SAMPLE_STROBE_N && PIN_UPDATE_STROBE_N)
		else $error("reset code left port active");
	dir_hold_a: assert property (
		!MODE_CMD.valid |=> $stable(PIN_OE))
		else $error("direction changed without setup");
	sync_update_a: assert property (
		st_q.mode == ubbpp_pkg::M_SYNC && $past(st_q.mode) == ubbpp_pkg::M_SYNC
		&& $changed(PIN_OUT)
		|-> $past(st_q.seq) == ubbpp_pkg::S_APPLY)
		else $error("sync outputs changed outside apply");
	sync_sample_a: assert property (
		st_q.mode == ubbpp_pkg::M_SYNC && st_q.push
		|-> $past(st_q.seq) == ubbpp_pkg::S_SAMPLE && $past(st_q.pop))
		else $error("sync sample without written byte");
	sync_room_a: assert property (
		st_q.seq == ubbpp_pkg::S_SAMPLE |-> $past(p2h_ready) && $past(h2p_valid))
		else $error("sync byte started without room");
	seq_order_a: assert property (
		@(posedge CLK) disable iff (SRST || MODE_CMD.valid)
		rd_release_s |=> push_apply_s)
		else $error("sample and apply out of order");
	wr_delay_a: assert property (
		@(posedge CLK) disable iff (SRST || MODE_CMD.valid)
		st_q.seq == ubbpp_pkg::S_APPLY |=> wr_pulse_s)
		else $error("write strobe not one clock after output");
	async_pace_a: assert property (
		st_q.mode == ubbpp_pkg::M_ASYNC && $fell(PIN_UPDATE_STROBE_N) |-> $past(tick, 2))
		else $error("async output not paced by baud tick");
	hold_a: assert property (
		!MODE_CMD.valid && !st_q.pop && st_q.seq != ubbpp_pkg::S_APPLY
		|=> $stable(PIN_OUT))
		else $error("output pins changed with no new byte");
endmodule

/* src/ubbpp_pkg.sv */
package ubbpp_pkg;
	// Data and buffer shape
	localparam int unsigned DATA_W = 8;
	localparam int unsigned FIFO_DEPTH = 16;
	// Mode codes carried by the mode-select command
	localparam logic [7:0] CODE_RESET = 8'h00;
	localparam logic [7:0] CODE_ASYNC = 8'h01;
	localparam logic [7:0] CODE_SYNC = 8'h04;
	// Reset values of the pin side
	localparam logic [7:0] DIR_RESET = 8'h00;
	localparam logic [7:0] PIN_OUT_RESET = 8'h00;
	// Smallest baud divisor; keeps ticks at least two cycles apart
	localparam logic [15:0] BAUD_DIV_MIN = 16'h0002;

	// Port variants
	typedef enum logic [1:0] {
		M_IDLE = 2'b00,
		M_ASYNC = 2'b01,
		M_SYNC = 2'b10
	} ubbpp_mode_type;

	// Steps of one synchronous byte
	typedef enum logic [2:0] {
		S_IDLE = 3'b000,
		S_SAMPLE = 3'b001,
		S_APPLY = 3'b010,
		S_SETUP = 3'b011,
		S_WSTB = 3'b100
	} ubbpp_seq_type;

	// Mode-select command from the host
	typedef struct packed {
		logic valid;
		logic [7:0] code;
		logic [7:0] mask;
	} ubbpp_cmd_type;

	// Whole state of the port controller
	typedef struct packed {
		ubbpp_mode_type mode;
		ubbpp_seq_type seq;
		logic [7:0] dir;
		logic [7:0] pin_out;
		logic [7:0] next_out;
		logic pop;
		logic push;
		logic [7:0] push_data;
		logic rd_n;
		logic wr_n;
	} ubbpp_state_type;

	localparam ubbpp_state_type STATE_RESET = '{
		mode: M_IDLE, seq: S_IDLE, dir: DIR_RESET, pin_out: PIN_OUT_RESET,
		next_out: PIN_OUT_RESET, pop: 1'b0, push: 1'b0, push_data: PIN_OUT_RESET,
		rd_n: 1'b1, wr_n: 1'b1};

	// Baud generator state
	typedef struct packed {
		logic [15:0] cnt;
		logic tick;
	} ubbpp_baud_type;

	// Unknown codes fall back to the idle variant
	function automatic ubbpp_mode_type decode_mode(input logic [7:0] code);
		if (code == CODE_ASYNC) begin
			return M_ASYNC;
		end else if (code == CODE_SYNC) begin
			return M_SYNC;
		end
		return M_IDLE;
	endfunction
endpackage

/* src/ubbpp_fifo.sv */
`timescale 1ns/1ps
module ubbpp_fifo #(
	parameter int unsigned W = 8,
	parameter int unsigned DEPTH = 16
) (
	input wire logic clk,
	input wire logic srst,
	input wire logic [W-1:0] in_data,
	input wire logic in_valid,
	output logic in_ready,
	output logic [W-1:0] out_data,
	output logic out_valid,
	input wire logic out_ready
);
	localparam int unsigned AW = $clog2(DEPTH);

	// Pointers, fill level and the output register
	typedef struct packed {
		logic [AW-1:0] wr;
		logic [AW-1:0] rd;
		logic [AW:0] cnt;
		logic room;
		logic ovalid;
		logic [W-1:0] odata;
	} ubbpp_fifo_state_type;

	logic [W-1:0] mem [DEPTH]; // Storage words
	ubbpp_fifo_state_type s_q; // Registered state
	ubbpp_fifo_state_type s_d; // Next state
	logic push; // Word accepted this cycle
	logic take; // Output word consumed this cycle
	logic load; // Output register refilled

	// Refill the output register whenever it is free and a word waits
	always_comb begin
		s_d = s_q;
		push = in_valid & s_q.room;
		take = out_ready & s_q.ovalid;
		load = (~s_q.ovalid | take) & (s_q.cnt != '0);
		if (push) begin
			s_d.wr = s_q.wr + AW'(1);
		end
		if (load) begin
			s_d.odata = mem[s_q.rd];
			s_d.rd = s_q.rd + AW'(1);
			s_d.ovalid = 1'b1;
		end else if (take) begin
			s_d.ovalid = 1'b0;
		end
		s_d.cnt = s_q.cnt + (AW+1)'(push) - (AW+1)'(load);
		// Room is held in a flop so the source sees a clean ready
		s_d.room = (s_d.cnt != (AW+1)'(DEPTH));
		if (srst) begin
			s_d = '0;
		end
	end

	// State register
	always_ff @(posedge clk) begin
		s_q <= s_d;
	end

	// Memory write port
	always_ff @(posedge clk) begin
		if (push) begin
			mem[s_q.wr] <= in_data;
		end
	end

	assign in_ready = s_q.room; // Straight from a flop; low while in reset and while all DEPTH storage words are full
	assign out_valid = s_q.ovalid;
	assign out_data = s_q.odata;
endmodule

/* src/ubbpp_baud.sv */
`timescale 1ns/1ps
module ubbpp_baud (
	input wire logic clk,
	input wire logic srst,
	input wire logic run,
	input wire logic [15:0] div,
	output logic tick
);
	ubbpp_pkg::ubbpp_baud_type b_q; // Counter and tick
	ubbpp_pkg::ubbpp_baud_type b_d; // Next value
	logic [15:0] lim; // Clamped divisor

	// Count up to the divisor; restart whenever the port is not pacing
	always_comb begin
		lim = (div < ubbpp_pkg::BAUD_DIV_MIN) ? ubbpp_pkg::BAUD_DIV_MIN : div;
		b_d = b_q;
		b_d.tick = 1'b0;
		if (b_q.cnt >= lim - 16'h0001) begin
			b_d.cnt = 16'h0000;
			b_d.tick = 1'b1;
		end else begin
			b_d.cnt = b_q.cnt + 16'h0001;
		end
		if (srst || !run) begin
			b_d = '0;
		end
	end

	// State register
	always_ff @(posedge clk) begin
		b_q <= b_d;
	end

	assign tick = b_q.tick;
endmodule

/* test/ubbpp_pin_model.sv */
`timescale 1ns/1ps
// Outside logic on the pins, counting the port strobes on clk
module ubbpp_pin_model (
	input wire logic clk,
	input wire logic [7:0] pin_out,
	input wire logic [7:0] pin_oe,
	input wire logic smp_n,
	input wire logic upd_n,
	input wire logic [7:0] ext_level,
	output logic [7:0] pin_in,
	output int upd_cnt,
	output int smp_cnt,
	output int upd_gap
);
	int cyc; // Free running cycle count
	int last_upd; // Cycle of the previous update strobe
	logic upd_q; // Strobe levels one cycle back
	logic smp_q;

	// Driven bits follow the port, released bits follow the outside logic
	assign pin_in = (pin_out & pin_oe) | (ext_level & ~pin_oe);

	initial begin
		cyc = 0;
		last_upd = 0;
		upd_cnt = 0;
		smp_cnt = 0;
		upd_gap = 0;
		upd_q = 1'b1;
		smp_q = 1'b1;
	end

	// Count strobe edges; sample strobe rest level differs per mode, so count any change
	always @(posedge clk) begin
		cyc <= cyc + 1;
		upd_q <= upd_n;
		smp_q <= smp_n;
		if (upd_q === 1'b1 && upd_n === 1'b0) begin
			upd_cnt <= upd_cnt + 1;
			upd_gap <= cyc - last_upd;
			last_upd <= cyc;
		end
		if (smp_q !== smp_n) begin
			smp_cnt <= smp_cnt + 1;
		end
	end
endmodule

/* test/usb_bit_bang_parallel_port_tb_top.sv */
`timescale 1ns/1ps
module usb_bit_bang_parallel_port_tb_top;
	logic clk = 1'b0;
	logic srst = 1'b1;
	ubbpp_pkg::ubbpp_cmd_type mode_cmd = '0;
	logic [15:0] baud_div = 16'h0004;
	logic [7:0] wr_data = 8'h00;
	logic wr_valid = 1'b0;
	logic wr_ready;
	logic [7:0] rd_data;
	logic rd_valid;
	logic rd_ready = 1'b0;
	logic [7:0] pin_in;
	logic [7:0] pin_out;
	logic [7:0] pin_oe;
	logic smp_n;
	logic upd_n;
	logic [7:0] ext_level = 8'h00; // Level the outside logic puts on released pins
	int upd_cnt;
	int smp_cnt;
	int upd_gap;
	int n_mismatch = 0;
	int tests_run = 0;

	ubbpp_top dut (.CLK(clk), .SRST(srst), .MODE_CMD(mode_cmd), .BAUD_DIV(baud_div),
		.HOST_WR_DATA(wr_data), .HOST_WR_VALID(wr_valid), .HOST_WR_READY(wr_ready),
		.HOST_RD_DATA(rd_data), .HOST_RD_VALID(rd_valid), .HOST_RD_READY(rd_ready),
		.PIN_IN(pin_in), .PIN_OUT(pin_out), .PIN_OE(pin_oe),
		.PIN_SAMPLE_STROBE_N(smp_n), .PIN_UPDATE_STROBE_N(upd_n));

	ubbpp_pin_model pins (.clk(clk), .pin_out(pin_out), .pin_oe(pin_oe), .smp_n(smp_n),
		.upd_n(upd_n), .ext_level(ext_level), .pin_in(pin_in), .upd_cnt(upd_cnt),
		.smp_cnt(smp_cnt), .upd_gap(upd_gap));

	// 100 MHz clock
	initial begin
		forever #5 clk = ~clk;
	end

	// Inputs always move 1 ns after the edge, away from sampling
	task automatic step(input int n = 1);
		repeat (n) @(posedge clk);
		#1;
	endtask

	task automatic check(input string what, input logic [31:0] exp, input logic [31:0] got);
		tests_run++;
		if (got !== exp) begin
			n_mismatch++;
			$display("BAD %s expected %0h seen %0h", what, exp, got);
		end
	endtask

	task automatic results();
		$display("checks %0d mismatches %0d", tests_run, n_mismatch);
		if (n_mismatch == 0 && tests_run > 0) begin
			$display("TEST PASSED");
		end else begin
			$display("TEST FAILED");
		end
		$finish;
	endtask

	// A wait that ran out ends the run
	task automatic hang(input string what);
		n_mismatch++;
		$display("BAD %s expected handshake seen none", what);
		results();
	endtask

	// One-cycle command pulse; code and mask travel together
	task automatic set_mode(input logic [7:0] code, input logic [7:0] mask);
		mode_cmd = '{valid: 1'b1, code: code, mask: mask};
		step();
		mode_cmd.valid = 1'b0;
		step();
	endtask

	// Valid held until an edge sees ready; idle cycle after so valid never toggles twice
	task automatic put(input logic [7:0] b);
		int i;
		wr_data = b;
		wr_valid = 1'b1;
		for (i = 0; i < 300 && wr_ready !== 1'b1; i++) step();
		if (i == 300) hang("write ready");
		step();
		wr_valid = 1'b0;
		step();
	endtask

	task automatic get(input logic [7:0] exp);
		int i;
		rd_ready = 1'b1;
		for (i = 0; i < 300 && rd_valid !== 1'b1; i++) step();
		if (i == 300) hang("sample valid");
		check("sample", exp, rd_data);
		step();
		rd_ready = 1'b0;
		step();
	endtask

	task automatic t_reset();
		check("oe reset", 8'h00, pin_oe);
		check("out reset", 8'h00, pin_out);
		check("wr ready", 1'b1, wr_ready);
		check("upd rest", 1'b1, upd_n);
	endtask

	// Returned samples trail the written bytes by one
	task automatic t_sync();
		int u;
		set_mode(ubbpp_pkg::CODE_SYNC, 8'hFF);
		check("oe sync", 8'hFF, pin_oe);
		u = upd_cnt;
		put(8'h55);
		put(8'hAA);
		put(8'hAA);
		get(8'h00);
		get(8'h55);
		get(8'hAA);
		check("upd pulses", 3, upd_cnt - u);
		check("out sync", 8'hAA, pin_out);
		step(40);
		check("spare sample", 1'b0, rd_valid);
		check("upd quiet", 3, upd_cnt - u);
		check("out held", 8'hAA, pin_out);
	endtask

	// All pins inputs: writes still trigger sampling
	task automatic t_inputs();
		int u;
		ext_level = 8'h3C;
		set_mode(ubbpp_pkg::CODE_SYNC, 8'h00);
		check("oe inputs", 8'h00, pin_oe);
		u = upd_cnt;
		put(8'h77);
		get(8'h3C);
		check("upd inputs", 1, upd_cnt - u);
	endtask

	// Divisor 8 leaves room for the second byte to reach the head before the next tick
	task automatic t_async();
		int u;
		int s;
		int i;
		baud_div = 16'h0008;
		rd_ready = 1'b1;
		set_mode(ubbpp_pkg::CODE_ASYNC, 8'hF0);
		check("oe async", 8'hF0, pin_oe);
		u = upd_cnt;
		s = smp_cnt;
		put(8'hA5);
		put(8'h3C);
		for (i = 0; i < 300 && upd_cnt - u < 2; i++) step();
		if (i == 300) hang("async pulses");
		check("async pulses", 2, upd_cnt - u);
		check("async out", 8'h30, pin_out & pin_oe);
		check("async gap", 8, upd_gap);
		check("smp moved", 1, smp_cnt != s);
		step(30);
		check("async hold", 8'h30, pin_out & pin_oe);
		set_mode(ubbpp_pkg::CODE_RESET, 8'h00);
		step(5);
		rd_ready = 1'b0;
	endtask

	// Idle keeps bytes until the buffer refuses; sync then stalls on a full sample path
	task automatic t_buffer();
		int n;
		int u;
		int m;
		int i;
		// Unknown code must fall back to the idle variant
		set_mode(8'h02, 8'hFF);
		check("oe idle", 8'h00, pin_oe);
		check("out idle", 8'h00, pin_out);
		wr_valid = 1'b1;
		for (n = 0; n < 40 && wr_ready === 1'b1; n++) begin
			wr_data = n[7:0];
			step();
		end
		wr_valid = 1'b0;
		step();
		check("fill count", ubbpp_pkg::FIFO_DEPTH + 1, n);
		u = upd_cnt;
		set_mode(ubbpp_pkg::CODE_SYNC, 8'hFF);
		for (; n < 24; n++) put(n[7:0]);
		step(150);
		m = upd_cnt - u;
		step(30);
		check("stall held", m, upd_cnt - u);
		check("stall count", ubbpp_pkg::FIFO_DEPTH + 1, m);
		for (i = 0; i < 24; i++) get((i == 0) ? 8'h00 : 8'(i - 1));
		check("all bytes", 24, upd_cnt - u);
	endtask

	initial begin
		step(12);
		srst = 1'b0;
		step();
		t_reset();
		t_sync();
		t_inputs();
		t_async();
		t_buffer();
		results();
	end
endmodule
